// ### rtl/tbc_pkg.sv
package tbc_pkg;

  // Clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_HZ = 256;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int DIV_W = 18;

  // Bus shape
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;
  localparam int NIB_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CT_FLAGS = 12'hF00;
  localparam logic [11:0] IDX_SW_FLAGS = 12'hF01;
  localparam logic [11:0] IDX_CT_MASKS = 12'hF10;
  localparam logic [11:0] IDX_SW_MASKS = 12'hF11;
  localparam logic [11:0] IDX_CT_LOW = 12'hF20;
  localparam logic [11:0] IDX_CT_HIGH = 12'hF21;
  localparam logic [11:0] IDX_SW_HUND = 12'hF22;
  localparam logic [11:0] IDX_SW_TENTHS = 12'hF23;
  localparam logic [11:0] IDX_RST_STROBES = 12'hF76;
  localparam logic [11:0] IDX_SW_CTL = 12'hF77;

  // Field positions
  localparam int CT_CLR_BIT = 1;
  localparam int SW_RUN_BIT = 0;
  localparam int SW_CLR_BIT = 1;
  localparam int TAP_32HZ = 2;
  localparam int TAP_8HZ = 4;
  localparam int TAP_2HZ = 6;
  localparam int TAP_1HZ = 7;

  // Values
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [1:0] PAIR_ZERO = 2'h0;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [1:0] STEP_SHORT = 2'h2;
  localparam logic [1:0] STEP_LONG = 2'h3;

endpackage

// ### rtl/tbc_stopwatch.sv
`timescale 1ns/100ps
module tbc_stopwatch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  output logic [3:0] hundredths_digit,
  output logic [3:0] tenths_digit,
  output logic hund_ovf,
  output logic tenths_ovf
);

  // Four short and six long tenths periods add up to 256 ticks
  function automatic logic [1:0] step_len(input logic [3:0] h,
                                          input logic [3:0] t);
    logic long_period;
    long_period = !(t == 4'h0 || t == 4'h3 || t == 4'h5 || t == 4'h8); // [R13]
    if (h[0] || (long_period && h == tbc_pkg::NIB_ZERO)) begin // [R12]
      step_len = tbc_pkg::STEP_LONG;
    end else begin
      step_len = tbc_pkg::STEP_SHORT;
    end
  endfunction

  logic [1:0] phase_q, phase_d;
  logic [3:0] hund_q, hund_d, tenth_q, tenth_d;
  logic [1:0] len_w;
  logic step_w;

  assign len_w = step_len(hund_q, tenth_q);
  // Frozen phase keeps the sub-step position across a stop
  assign step_w = tick & run & ~clear & ((phase_q + 2'h1) == len_w); // [R12]
  assign hund_ovf = step_w & (hund_q == tbc_pkg::BCD_MAX);
  assign tenths_ovf = hund_ovf & (tenth_q == tbc_pkg::BCD_MAX);

  always_comb begin
    phase_d = phase_q;
    hund_d = hund_q;
    tenth_d = tenth_q;
    if (clear) begin // [R21]
      phase_d = 2'h0;
      hund_d = tbc_pkg::NIB_ZERO;
      tenth_d = tbc_pkg::NIB_ZERO;
    end else if (tick && run) begin // [R20]
      phase_d = step_w ? 2'h0 : phase_q + 2'h1;
      if (step_w) begin // [R11]
        hund_d = hund_ovf ? tbc_pkg::NIB_ZERO : hund_q + 4'h1;
      end
      if (hund_ovf) begin // [R11]
        tenth_d = tenths_ovf ? tbc_pkg::NIB_ZERO : tenth_q + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin // [R17]
      phase_q <= 2'h0;
      hund_q <= tbc_pkg::NIB_ZERO;
      tenth_q <= tbc_pkg::NIB_ZERO;
    end else begin
      phase_q <= phase_d;
      hund_q <= hund_d;
      tenth_q <= tenth_d;
    end
  end

  assign hundredths_digit = hund_q;
  assign tenths_digit = tenth_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bcd_range: assert property ( // [R17]
    hund_q <= tbc_pkg::BCD_MAX && tenth_q <= tbc_pkg::BCD_MAX)
    else $error("stopwatch digit left BCD range");
  a_stop_holds: assert property ( // [R20]
    !run && !clear |=> $stable(hund_q) && $stable(tenth_q))
    else $error("stopwatch counted while stopped");
  a_tenths_carry: assert property ( // [R11]
    hund_ovf |=> hund_q == 4'h0 && tenth_q != $past(tenth_q))
    else $error("hundredths wrap did not step tenths");
  a_clear_zero: assert property ( // [R21]
    clear |=> hund_q == 4'h0 && tenth_q == 4'h0 && phase_q == 2'h0)
    else $error("stopwatch clear left digits");
  a_step_gap: assert property ( // [R12]
    step_w |=> !step_w)
    else $error("stopwatch steps too close");

endmodule

// ### rtl/tbc_top.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// Function
// R01: Eight-bit binary clock divider advances on every 256 Hz tick.
// R02: Low nibble bit 0 is 128 Hz; high nibble bit 3 is 1 Hz.
// R03: Falling edges of 32, 8, 2 and 1 Hz stages set own flags.
// R04: Clock flags set regardless of mask; mask gates only the request.
// R05: Clock masks read and write, one enables, reset clears them.
// R06: Reading clock flags clears those set; writes ignored; reset zero.
// R07: Writing one to divider clear bit D1 zeroes counter; reads zero.
// R08: Divider clear may set a flag by a falling stage; tolerated.
// R09: Both divider nibbles read-only, writes ignored, zero after reset.
// R10: Flag and mask bits D3..D0 serve 1, 2, 8 and 32 Hz.
// R11: Stopwatch is hundredths digit cascading carry into tenths digit.
// R12: Hundredths steps every 2 or 3 ticks, 25 or 26 per digit.
// R13: Tenths sees 25 and 26 tick periods in four to six ratio.
// R14: Hundredths wrap sets 10 Hz flag; tenths wrap sets 1 Hz flag.
// R15: Each stopwatch flag has own mask; flags set whatever mask.
// R16: Stopwatch flag and mask: D0 10 Hz, D1 1 Hz, upper zero.
// R17: Both digits read as separate read-only BCD nibbles, zero at reset.
// R18: Software rereads divider nibbles until values match across a carry.
// R19: Interrupt request is OR of every flag and its mask.
// R20: Run bit one counts, zero freezes digits; reset clears it.
// R21: Stopwatch clear zeroes digits; running resumes at once; reads zero.
module tbc_top #(
  parameter int TICK_DIV = tbc_pkg::TICK_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [15:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);

  localparam int DW = tbc_pkg::DIV_W;
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_DIV - 1);

  // Word-aligned match of a byte address against a register index
  function automatic logic hit(input logic [15:0] a,
                               input logic [11:0] idx);
    hit = (a[15:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
  endfunction

  // Tick divider
  logic [DW-1:0] div_q;
  logic tick_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + DW'(1);
      tick_q <= (div_q == DIV_LAST);
    end
  end

  // Bus state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic aw_hold_q, w_hold_q, aw_hold_d, w_hold_d;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  wire aw_hs = awvalid & awready_q;
  wire w_hs = wvalid & wready_q;
  wire ar_hs = arvalid & arready_q;
  wire do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
  wire wr_lo = do_wr & wstrb0_q;

  // Write decode on the held address
  wire w_ctf = hit(awaddr_q, tbc_pkg::IDX_CT_FLAGS);
  wire w_swf = hit(awaddr_q, tbc_pkg::IDX_SW_FLAGS);
  wire w_ctm = hit(awaddr_q, tbc_pkg::IDX_CT_MASKS);
  wire w_swm = hit(awaddr_q, tbc_pkg::IDX_SW_MASKS);
  wire w_ctl = hit(awaddr_q, tbc_pkg::IDX_CT_LOW);
  wire w_cth = hit(awaddr_q, tbc_pkg::IDX_CT_HIGH);
  wire w_swh = hit(awaddr_q, tbc_pkg::IDX_SW_HUND);
  wire w_swt = hit(awaddr_q, tbc_pkg::IDX_SW_TENTHS);
  wire w_rst = hit(awaddr_q, tbc_pkg::IDX_RST_STROBES);
  wire w_swc = hit(awaddr_q, tbc_pkg::IDX_SW_CTL);
  // Flag and data registers decode but store nothing on write
  wire w_map = w_ctf | w_swf | w_ctm | w_swm | w_ctl | w_cth | w_swh |
               w_swt | w_rst | w_swc; // [R09]

  wire ct_clear = wr_lo & w_rst & wdata_q[tbc_pkg::CT_CLR_BIT]; // [R07]
  wire sw_clear = wr_lo & w_swc & wdata_q[tbc_pkg::SW_CLR_BIT]; // [R21]

  // Read decode on the live address
  wire r_ctf = hit(araddr, tbc_pkg::IDX_CT_FLAGS);
  wire r_swf = hit(araddr, tbc_pkg::IDX_SW_FLAGS);
  wire r_ctm = hit(araddr, tbc_pkg::IDX_CT_MASKS);
  wire r_swm = hit(araddr, tbc_pkg::IDX_SW_MASKS);
  wire r_ctl = hit(araddr, tbc_pkg::IDX_CT_LOW);
  wire r_cth = hit(araddr, tbc_pkg::IDX_CT_HIGH);
  wire r_swh = hit(araddr, tbc_pkg::IDX_SW_HUND);
  wire r_swt = hit(araddr, tbc_pkg::IDX_SW_TENTHS);
  wire r_rst = hit(araddr, tbc_pkg::IDX_RST_STROBES);
  wire r_swc = hit(araddr, tbc_pkg::IDX_SW_CTL);
  wire r_map = r_ctf | r_swf | r_ctm | r_swm | r_ctl | r_cth | r_swh |
               r_swt | r_rst | r_swc;

  // Clock divider and flags
  logic [7:0] cnt_q, cnt_d, fall_w;
  logic [3:0] ct_flags_q, ct_flags_d, ct_mask_q, ct_set, ct_rdclr;
  logic [1:0] sw_flags_q, sw_flags_d, sw_mask_q, sw_set, sw_rdclr;
  logic sw_run_q, irq_q;
  logic [3:0] hund_w, tenth_w;
  logic hund_ovf, tenths_ovf;

  // Clear has priority over a coincident tick
  assign cnt_d = ct_clear ? tbc_pkg::CNT_RESET :
                 tick_q ? cnt_q + 8'h01 : cnt_q; // [R01] [R07]
  // A clear drops high stages too, so it can raise a flag
  assign fall_w = cnt_q & ~cnt_d; // [R08]
  assign ct_set = {fall_w[tbc_pkg::TAP_1HZ], fall_w[tbc_pkg::TAP_2HZ],
                   fall_w[tbc_pkg::TAP_8HZ],
                   fall_w[tbc_pkg::TAP_32HZ]}; // [R03] [R10]
  assign sw_set = {tenths_ovf, hund_ovf}; // [R14] [R16]
  // Only the bits that were seen by the read are cleared
  assign ct_rdclr = (ar_hs && r_ctf) ? ct_flags_q : tbc_pkg::NIB_ZERO;
  assign sw_rdclr = (ar_hs && r_swf) ? sw_flags_q : tbc_pkg::PAIR_ZERO;
  // Set wins over a clear in the same cycle; masks play no part
  assign ct_flags_d = (ct_flags_q & ~ct_rdclr) | ct_set; // [R04] [R06]
  assign sw_flags_d = (sw_flags_q & ~sw_rdclr) | sw_set; // [R15]

  wire irq_any = |(ct_flags_q & ct_mask_q) | |(sw_flags_q & sw_mask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin // [R05] [R09]
      cnt_q <= tbc_pkg::CNT_RESET;
      ct_flags_q <= tbc_pkg::NIB_ZERO;
      sw_flags_q <= tbc_pkg::PAIR_ZERO;
      ct_mask_q <= tbc_pkg::NIB_ZERO;
      sw_mask_q <= tbc_pkg::PAIR_ZERO;
      sw_run_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ct_flags_q <= ct_flags_d;
      sw_flags_q <= sw_flags_d;
      if (wr_lo && w_ctm) begin // [R05]
        ct_mask_q <= wdata_q[3:0];
      end
      if (wr_lo && w_swm) begin // [R15] [R16]
        sw_mask_q <= wdata_q[1:0];
      end
      if (wr_lo && w_swc) begin // [R20]
        sw_run_q <= wdata_q[tbc_pkg::SW_RUN_BIT];
      end
      irq_q <= irq_any; // [R19]
    end
  end

  tbc_stopwatch u_sw (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_q),
    .run(sw_run_q),
    .clear(sw_clear),
    .hundredths_digit(hund_w),
    .tenths_digit(tenth_w),
    .hund_ovf(hund_ovf),
    .tenths_ovf(tenths_ovf)
  );

  // Read data; strobe bits always read zero
  wire [3:0] r_nib = ({4{r_ctf}} & ct_flags_q) |
                     ({4{r_swf}} & {2'h0, sw_flags_q}) |
                     ({4{r_ctm}} & ct_mask_q) |
                     ({4{r_swm}} & {2'h0, sw_mask_q}) |
                     ({4{r_ctl}} & cnt_q[3:0]) |
                     ({4{r_cth}} & cnt_q[7:4]) |
                     ({4{r_swh}} & hund_w) |
                     ({4{r_swt}} & tenth_w) |
                     ({4{r_swc}} & {3'h0, sw_run_q}); // [R02] [R16] [R17]

  // Write channel: address and data taken in either order
  assign aw_hold_d = aw_hs | (aw_hold_q & ~do_wr);
  assign w_hold_d = w_hs | (w_hold_q & ~do_wr);
  assign bvalid_d = do_wr | (bvalid_q & ~bready);
  assign awready_d = ~aw_hold_d & ~bvalid_d;
  assign wready_d = ~w_hold_d & ~bvalid_d;
  assign rvalid_d = ar_hs | (rvalid_q & ~rready);
  assign arready_d = ~rvalid_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 16'h0000;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      bresp_q <= tbc_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
      rresp_q <= tbc_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_q <= awaddr;
      end
      if (w_hs) begin
        wdata_q <= wdata;
        wstrb0_q <= wstrb[0];
      end
      if (do_wr) begin
        bresp_q <= w_map ? tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
      end
      if (ar_hs) begin
        rdata_q <= {28'h0000000, r_nib};
        rresp_q <= r_map ? tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cnt_advance: assert property ( // [R01]
    tick_q && !ct_clear |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("divider did not advance on tick");
  a_flag_32hz: assert property ( // [R03]
    $fell(cnt_q[2]) |-> ct_flags_q[0])
    else $error("32 Hz fall did not set its flag");
  a_flag_1hz_bit: assert property ( // [R10]
    $fell(cnt_q[7]) |-> ct_flags_q[3])
    else $error("1 Hz fall did not set flag bit 3");
  a_flag_unmasked: assert property ( // [R04]
    $fell(cnt_q[6]) && !ct_mask_q[2] |-> ct_flags_q[2])
    else $error("masked 2 Hz flag was not set");
  a_flag_read_clr: assert property ( // [R06]
    ar_hs && r_ctf && ct_set == 4'h0 |=> ct_flags_q == 4'h0 && rvalid_q)
    else $error("flag read did not clear flags");
  a_div_clear: assert property ( // [R07]
    ct_clear |=> cnt_q == 8'h00)
    else $error("divider clear left count");
  a_mask_reset: assert property ( // [R05]
    $rose(aresetn) |-> ct_mask_q == 4'h0 && sw_mask_q == 2'h0)
    else $error("masks not zero after reset");
  a_irq_raise: assert property ( // [R19]
    irq_any |=> irq_q)
    else $error("request missing for enabled flag");
  a_irq_drop: assert property ( // [R19]
    !irq_any |=> !irq_q)
    else $error("request without enabled flag");
  a_sw_flag_set: assert property ( // [R14]
    hund_ovf |=> sw_flags_q[0])
    else $error("hundredths wrap did not set flag");
  a_sw_upper_zero: assert property ( // [R16]
    ar_hs && (r_swf || r_swm) |=> rvalid_q && rdata_q[31:2] == 30'h0)
    else $error("stopwatch upper bits not zero");
  a_cnt_hold: assert property ( // [R01]
    !tick_q && !ct_clear |=> $stable(cnt_q))
    else $error("divider moved without a tick");
  a_low_read: assert property ( // [R02]
    ar_hs && r_ctl |=> rdata_q[3:0] == $past(cnt_q[3:0]))
    else $error("low divider nibble read wrong");
  a_high_read: assert property ( // [R02]
    ar_hs && r_cth |=> rdata_q[3:0] == $past(cnt_q[7:4]))
    else $error("high divider nibble read wrong");
  a_flag_8hz: assert property ( // [R03]
    $fell(cnt_q[tbc_pkg::TAP_8HZ]) |-> ct_flags_q[1])
    else $error("8 Hz fall did not set its flag");
  a_mask_write: assert property ( // [R05]
    wr_lo && w_ctm |=> ct_mask_q == $past(wdata_q[3:0]))
    else $error("clock mask write lost");
  a_flag_write_ign: assert property ( // [R06]
    do_wr && w_ctf && ct_set == 4'h0 && !(ar_hs && r_ctf) |=>
    ct_flags_q == $past(ct_flags_q))
    else $error("write changed clock flags");
  a_clear_reads_zero: assert property ( // [R07]
    ar_hs && (r_rst || r_swc) |=> rdata_q[3:1] == 3'h0)
    else $error("strobe bit did not read zero");
  a_clear_sets_flag: assert property ( // [R08]
    ct_clear && cnt_q[tbc_pkg::TAP_32HZ] |=> ct_flags_q[0])
    else $error("clear fall did not set 32 Hz flag");
  a_data_read_only: assert property ( // [R09]
    do_wr && (w_ctl || w_cth) && !tick_q |=> $stable(cnt_q))
    else $error("write changed divider");
  a_sw_flag_1hz: assert property ( // [R14]
    tenths_ovf |=> sw_flags_q[1])
    else $error("tenths wrap did not set flag");
  a_sw_mask_write: assert property ( // [R16]
    wr_lo && w_swm |=> sw_mask_q == $past(wdata_q[1:0]))
    else $error("stopwatch mask write lost");
  a_hund_read: assert property ( // [R17]
    ar_hs && r_swh |=> rdata_q[3:0] == $past(hund_w))
    else $error("hundredths read wrong");
  a_tenths_read: assert property ( // [R17]
    ar_hs && r_swt |=> rdata_q[3:0] == $past(tenth_w))
    else $error("tenths read wrong");
  a_run_write: assert property ( // [R20]
    wr_lo && w_swc |=> sw_run_q == $past(wdata_q[tbc_pkg::SW_RUN_BIT]))
    else $error("run bit write lost");

  c_flag_1hz: cover property ($fell(cnt_q[7]));
  c_tenths_wrap: cover property (tenths_ovf);
  c_flag_read: cover property (ar_hs && r_ctf && ct_flags_q != 4'h0);
  c_sw_clear: cover property (sw_clear && sw_run_q);
  c_clear_flag: cover property (ct_clear && cnt_q[tbc_pkg::TAP_32HZ]);

endmodule

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int T = 16;
  localparam logic [11:0] IDXS [10] = '{tbc_pkg::IDX_CT_LOW,
    tbc_pkg::IDX_CT_HIGH, tbc_pkg::IDX_CT_FLAGS, tbc_pkg::IDX_SW_FLAGS,
    tbc_pkg::IDX_CT_MASKS, tbc_pkg::IDX_SW_MASKS, tbc_pkg::IDX_SW_HUND,
    tbc_pkg::IDX_SW_TENTHS, tbc_pkg::IDX_RST_STROBES, tbc_pkg::IDX_SW_CTL};
  logic aclk;
  logic aresetn;
  logic [15:0] awaddr;
  logic [15:0] araddr;
  logic [2:0] awprot;
  logic [2:0] arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] v;
  logic [31:0] h;
  logic [7:0] c;
  logic [1:0] rs;
  int failures;
  int cmp_count;

  tbc_top #(.TICK_DIV(T)) dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));

  always #12.5 aclk = ~aclk;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Address and data are offered together; each is dropped once taken
  task automatic wr(input logic [11:0] idx, input logic [3:0] d,
                    input logic [1:0] er);
    int n;
    bit ad;
    bit wd;
    n = 0;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {28'h0000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd) && n < 50) begin
      @(posedge aclk);
      n++;
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'h0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    bready <= 1'h0;
    if (n >= 50) chk("write_wait", 32'h0, 32'h1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [11:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'h1 && n < 50);
    arvalid <= 1'h0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'h1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (n >= 50) chk("read_wait", 32'h0, 32'h1);
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk($sformatf("reg_%h", idx), e, d);
    chk("rresp", 32'h0, {30'h0, r});
  endtask

  // Nibbles may tear across a carry, so low is reread until it agrees
  task automatic rd_div(output logic [7:0] cnt);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] lo2;
    logic [1:0] r;
    for (int k = 0; k < 4; k++) begin
      rd(tbc_pkg::IDX_CT_LOW, lo, r);
      rd(tbc_pkg::IDX_CT_HIGH, hi, r);
      rd(tbc_pkg::IDX_CT_LOW, lo2, r);
      if (lo === lo2) break;
    end
    cnt = {hi[3:0], lo[3:0]};
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    chk("watchdog", 32'h0, 32'h1);
    test_done;
  end

  initial begin
    aclk = 1'h0;
    aresetn <= 1'h0;
    awaddr <= 16'h0000;
    araddr <= 16'h0000;
    awprot <= 3'h0;
    arprot <= 3'h0;
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    arvalid <= 1'h0;
    bready <= 1'h0;
    rready <= 1'h0;
    wdata <= 32'h0;
    wstrb <= 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      rdc(IDXS[i], 32'h0);
    end
    rd(12'hF30, v, rs);
    chk("unmapped_rdata", 32'h0, v);
    chk("unmapped_rresp", {30'h0, tbc_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(12'hF30, 4'hF, tbc_pkg::RESP_SLVERR);
    $display("test reset_values done");

    wr(tbc_pkg::IDX_CT_MASKS, 4'hF, tbc_pkg::RESP_OKAY);
    rdc(tbc_pkg::IDX_CT_MASKS, 32'hF);
    wr(tbc_pkg::IDX_SW_MASKS, 4'hF, tbc_pkg::RESP_OKAY);
    rdc(tbc_pkg::IDX_SW_MASKS, 32'h3);
    wr(tbc_pkg::IDX_CT_MASKS, 4'h0, tbc_pkg::RESP_OKAY);
    wr(tbc_pkg::IDX_SW_MASKS, 4'h0, tbc_pkg::RESP_OKAY);
    $display("test masks done");

    wr(tbc_pkg::IDX_RST_STROBES, 4'h2, tbc_pkg::RESP_OKAY);
    rd(tbc_pkg::IDX_CT_FLAGS, v, rs);
    rdc(tbc_pkg::IDX_CT_FLAGS, 32'h0);
    rdc(tbc_pkg::IDX_RST_STROBES, 32'h0);
    rd_div(c);
    chk("div_after_clear", 32'h1, {31'h0, c <= 8'h03});
    wr(tbc_pkg::IDX_CT_HIGH, 4'hF, tbc_pkg::RESP_OKAY);
    rdc(tbc_pkg::IDX_CT_HIGH, 32'h0);
    wr(tbc_pkg::IDX_RST_STROBES, 4'h2, tbc_pkg::RESP_OKAY);
    repeat (100 * T) @(posedge aclk);
    rd_div(c);
    chk("div_rate", 32'h1, {31'h0, c >= 8'h63 && c <= 8'h66});
    $display("test divider done");

    wr(tbc_pkg::IDX_RST_STROBES, 4'h2, tbc_pkg::RESP_OKAY);
    rd(tbc_pkg::IDX_CT_FLAGS, v, rs);
    repeat (262 * T) @(posedge aclk);
    irq_is(1'h0);
    wr(tbc_pkg::IDX_CT_FLAGS, 4'h0, tbc_pkg::RESP_OKAY);
    wr(tbc_pkg::IDX_CT_MASKS, 4'h8, tbc_pkg::RESP_OKAY);
    irq_is(1'h1);
    rdc(tbc_pkg::IDX_CT_FLAGS, 32'hF);
    irq_is(1'h0);
    repeat (9 * T) @(posedge aclk);
    irq_is(1'h0);
    wr(tbc_pkg::IDX_CT_MASKS, 4'h1, tbc_pkg::RESP_OKAY);
    irq_is(1'h1);
    rdc(tbc_pkg::IDX_CT_MASKS, 32'h1);
    wr(tbc_pkg::IDX_CT_MASKS, 4'h0, tbc_pkg::RESP_OKAY);
    $display("test clock_flags done");

    wr(tbc_pkg::IDX_SW_CTL, 4'h3, tbc_pkg::RESP_OKAY);
    rdc(tbc_pkg::IDX_SW_CTL, 32'h1);
    repeat (270 * T) @(posedge aclk);
    wr(tbc_pkg::IDX_SW_CTL, 4'h0, tbc_pkg::RESP_OKAY);
    wr(tbc_pkg::IDX_SW_MASKS, 4'h2, tbc_pkg::RESP_OKAY);
    irq_is(1'h1);
    rdc(tbc_pkg::IDX_SW_FLAGS, 32'h3);
    irq_is(1'h0);
    wr(tbc_pkg::IDX_SW_MASKS, 4'h0, tbc_pkg::RESP_OKAY);
    rdc(tbc_pkg::IDX_SW_TENTHS, 32'h0);
    rd(tbc_pkg::IDX_SW_HUND, h, rs);
    chk("hund_after_1s", 32'h1, {31'h0, h >= 32'h3 && h <= 32'h7});
    repeat (200) @(posedge aclk);
    rdc(tbc_pkg::IDX_SW_HUND, h);
    wr(tbc_pkg::IDX_SW_CTL, 4'h2, tbc_pkg::RESP_OKAY);
    rdc(tbc_pkg::IDX_SW_HUND, 32'h0);
    rdc(tbc_pkg::IDX_SW_TENTHS, 32'h0);
    repeat (100) @(posedge aclk);
    rdc(tbc_pkg::IDX_SW_HUND, 32'h0);
    rdc(tbc_pkg::IDX_SW_CTL, 32'h0);
    wr(tbc_pkg::IDX_SW_CTL, 4'h1, tbc_pkg::RESP_OKAY);
    repeat (25 * T) @(posedge aclk);
    wr(tbc_pkg::IDX_SW_CTL, 4'h0, tbc_pkg::RESP_OKAY);
    rd(tbc_pkg::IDX_SW_TENTHS, v, rs);
    rd(tbc_pkg::IDX_SW_HUND, h, rs);
    v = v * 10 + h;
    chk("steps_in_25_ticks", 32'h1,
        {31'h0, v >= 32'h8 && v <= 32'hB});
    // Clear while running must restart the count at once
    wr(tbc_pkg::IDX_SW_CTL, 4'h1, tbc_pkg::RESP_OKAY);
    wr(tbc_pkg::IDX_SW_CTL, 4'h3, tbc_pkg::RESP_OKAY);
    repeat (10 * T) @(posedge aclk);
    wr(tbc_pkg::IDX_SW_CTL, 4'h0, tbc_pkg::RESP_OKAY);
    rdc(tbc_pkg::IDX_SW_HUND, 32'h4);
    rdc(tbc_pkg::IDX_SW_TENTHS, 32'h0);
    $display("test stopwatch done");
    test_done;
  end
endmodule
